// File: rtl/rmad_pkg.sv
// Overview of operation
// R1: Seventeen register maps share one I2C-compatible two-wire serial slave port.
// R2: Main I/O map answers at fixed bus address 0x40, never changeable.
// R3: Transmitter map answers at fixed bus address 0xB8, never changeable.
// R4: Other maps reset to address 0x00; host assigns unique addresses before use.
// R5: Blanking data processor map address comes from I/O register 0xFE.
// R6: Component processor map address comes from I/O register 0xFD.
// R7: Receiver map address comes from I/O register 0xFB.
// R8: Receiver EDID map address comes from I/O register 0xFA.
// R9: Key selection vector map address comes from I/O register 0xF9.
// R10: Analog front end map address comes from I/O register 0xF8.
// R11: Info packet map address comes from I/O register 0xF5.
// R12: Standard definition I/O map address comes from I/O register 0xF2.
// R13: Standard definition processor map address comes from I/O register 0xF1.
// R14: Transmitter EDID map address comes from I/O register 0xF0.
// R15: Transmitter user packet map address comes from I/O register 0xEF.
// R16: Video front end map address comes from I/O register 0xEC.
// R17: Memory control map address comes from I/O register 0xEB.
// R18: Audio codec map address comes from I/O register 0xE7.
// R19: Transmitter test map address comes from I/O register 0xE3.
// R20: Acknowledge only matching fixed or programmed nonzero addresses; zero stays unreachable.
// R21: Map address writes apply to every transaction starting after the write.
`default_nettype none
package rmad_pkg;
	// ****************************************
	// Map counts and fixed addresses
	// ****************************************
	localparam int         MAP_CNT     = 17;
	localparam int         PROG_CNT    = 15;
	localparam logic [7:0] IO_MAP_ADDR = 8'h40;
	localparam logic [7:0] TX_MAP_ADDR = 8'hB8;
	localparam logic [7:0] PROG_RST    = 8'h00;
	// Offsets of the map address registers, index 14 first
	localparam logic [PROG_CNT-1:0][7:0] PROG_OFFS = {
		8'hE3, 8'hE7, 8'hEB, 8'hEC, 8'hEF, 8'hF0, 8'hF1, 8'hF2,
		8'hF5, 8'hF8, 8'hF9, 8'hFA, 8'hFB, 8'hFD, 8'hFE};
	// Map select codes
	localparam logic [4:0] MAP_IO    = 5'h00;
	localparam logic [4:0] MAP_TX    = 5'h01;
	localparam logic [4:0] MAP_PROG0 = 5'h02;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] CNT_ZERO  = 4'h0;
	localparam logic [3:0] CNT_ONE   = 4'h1;
	localparam logic [7:0] PTR_STEP  = 8'h01;
	// ****************************************
	// State and register types
	// ****************************************
	typedef enum logic [3:0] {
		ST_IDLE     = 4'b0000,
		ST_ADDR     = 4'b0001,
		ST_ACK_ADDR = 4'b0010,
		ST_OFFS     = 4'b0011,
		ST_ACK_OFFS = 4'b0100,
		ST_WDATA    = 4'b0101,
		ST_ACK_W    = 4'b0110,
		ST_RDATA    = 4'b0111,
		ST_ACK_R    = 4'b1000
	} rmad_state_t;
	typedef struct packed {
		rmad_state_t                st;
		logic [3:0]                 cnt;
		logic [7:0]                 shift;
		logic [4:0]                 map;
		logic                       nack;
		logic                       scl;
		logic                       sda;
		logic                       oe;
		logic [7:0]                 ptr;
		logic [PROG_CNT-1:0][7:0]   addr;
		logic                       wr;
		logic                       rd;
		logic [7:0]                 wdata;
	} rmad_reg_t;
endpackage : rmad_pkg
`default_nettype wire

// File: rtl/rmad_decode.sv
`timescale 1ns/1ps
`default_nettype none
module rmad_decode (
	input  wire logic       clk_in,
	input  wire logic       rst_b_in,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_out,
	output logic [4:0]      map_sel_out,
	output logic [7:0]      map_offs_out,
	output logic [7:0]      map_wdata_out,
	output logic            map_wr_out,
	output logic            map_rd_out,
	input  wire logic [7:0] map_rdata_in
);
	import rmad_pkg::*;

	// ****************************************
	// State registers
	// ****************************************
	rmad_reg_t q;
	rmad_reg_t d;
	logic      scl_rise;
	logic      scl_fall;
	logic      start_c;
	logic      stop_c;
	logic      hit;
	logic [4:0] hit_map;
	logic [7:0] rd_byte;

	// Bus edge and condition detection
	assign scl_rise = scl_in & ~q.scl;
	assign scl_fall = ~scl_in & q.scl;
	assign start_c  = scl_in & q.scl & q.sda & ~sda_in;
	assign stop_c   = scl_in & q.scl & ~q.sda & sda_in;

	// Address match against fixed and programmed maps, current values
	always_comb
	begin
		hit     = 1'b0;
		hit_map = MAP_IO;
		for (int i = PROG_CNT - 1; i >= 0; i--)
		begin
			if ((q.addr[i] != PROG_RST) && (q.addr[i][7:1] == q.shift[7:1])) // [R4] [R20] [R21]
			begin
				hit     = 1'b1;
				hit_map = 5'(MAP_PROG0 + 5'(i));
			end
		end
		if (q.shift[7:1] == TX_MAP_ADDR[7:1]) // [R3]
		begin
			hit     = 1'b1;
			hit_map = MAP_TX;
		end
		if (q.shift[7:1] == IO_MAP_ADDR[7:1]) // [R2]
		begin
			hit     = 1'b1;
			hit_map = MAP_IO;
		end
	end

	// Read data: address registers internal, all else from the map side
	always_comb
	begin
		rd_byte = map_rdata_in;
		for (int i = 0; i < PROG_CNT; i++)
		begin
			if ((q.map == MAP_IO) && (q.ptr == PROG_OFFS[i]))
			begin
				rd_byte = q.addr[i];
			end
		end
	end

	// ****************************************
	// Serial slave sequencing
	// ****************************************
	always_comb
	begin
		d     = q;
		d.scl = scl_in;
		d.sda = sda_in;
		d.wr  = 1'b0;
		d.rd  = 1'b0;
		if (start_c)
		begin
			d.st  = ST_ADDR; // One slave port for all maps [R1]
			d.cnt = CNT_ZERO;
			d.oe  = 1'b0;
		end
		else if (stop_c)
		begin
			d.st = ST_IDLE;
			d.oe = 1'b0;
		end
		else
		begin
			unique case (q.st)
				ST_IDLE:
				begin
					d.oe = 1'b0;
				end
				ST_ADDR, ST_OFFS, ST_WDATA:
				begin
					if (scl_rise)
					begin
						d.shift = {q.shift[6:0], sda_in};
						d.cnt   = 4'(q.cnt + CNT_ONE);
					end
					else if (scl_fall && (q.cnt == BYTE_BITS))
					begin
						d.cnt = CNT_ZERO;
						d.oe  = 1'b1;
						if (q.st == ST_ADDR)
						begin
							// Unmatched address is left unacknowledged [R20]
							d.st  = hit ? ST_ACK_ADDR : ST_IDLE;
							d.oe  = hit;
							d.map = hit_map;
							d.nack = q.shift[0];
						end
						else if (q.st == ST_OFFS)
						begin
							d.st  = ST_ACK_OFFS;
							d.ptr = q.shift;
						end
						else
						begin
							d.st    = ST_ACK_W;
							d.wr    = 1'b1;
							d.wdata = q.shift;
							// Map address registers [R5] [R6] [R7] [R8] [R9] [R10] [R11] [R12]
							// [R13] [R14] [R15] [R16] [R17] [R18] [R19]
							for (int i = 0; i < PROG_CNT; i++)
							begin
								if ((q.map == MAP_IO) && (q.ptr == PROG_OFFS[i]))
								begin
									d.addr[i] = q.shift;
								end
							end
						end
					end
				end
				ST_ACK_ADDR:
				begin
					if (scl_fall)
					begin
						if (q.nack)
						begin
							// Read: first byte driven right after the ack
							d.st    = ST_RDATA;
							d.shift = rd_byte;
							d.oe    = ~rd_byte[7];
							d.rd    = 1'b1;
						end
						else
						begin
							d.st = ST_OFFS;
							d.oe = 1'b0;
						end
					end
				end
				ST_ACK_OFFS, ST_ACK_W:
				begin
					if (scl_fall)
					begin
						d.st = ST_WDATA;
						d.oe = 1'b0;
						if (q.st == ST_ACK_W)
						begin
							d.ptr = 8'(q.ptr + PTR_STEP);
						end
					end
				end
				ST_RDATA:
				begin
					if (scl_fall)
					begin
						d.cnt = 4'(q.cnt + CNT_ONE);
						if (4'(q.cnt + CNT_ONE) == BYTE_BITS)
						begin
							d.st  = ST_ACK_R;
							d.oe  = 1'b0;
							d.cnt = CNT_ZERO;
							d.ptr = 8'(q.ptr + PTR_STEP);
						end
						else
						begin
							d.shift = {q.shift[6:0], 1'b0};
							d.oe    = ~q.shift[6];
						end
					end
				end
				ST_ACK_R:
				begin
					if (scl_rise)
					begin
						d.nack = sda_in;
					end
					else if (scl_fall)
					begin
						if (q.nack)
						begin
							d.st = ST_IDLE;
						end
						else
						begin
							d.st    = ST_RDATA;
							d.shift = rd_byte;
							d.oe    = ~rd_byte[7];
							d.rd    = 1'b1;
						end
					end
				end
				default:
				begin
					d.st = ST_IDLE;
					d.oe = 1'b0;
				end
			endcase
		end
	end

	// Register the state, all zero at reset
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	// Outputs
	assign sda_out       = 1'b0;
	assign sda_oe_out    = q.oe;
	assign map_sel_out   = q.map;
	assign map_offs_out  = q.ptr;
	assign map_wdata_out = q.wdata;
	assign map_wr_out    = q.wr;
	assign map_rd_out    = q.rd;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);

	sequence addr_end_s;
		(q.st == ST_ADDR) && scl_fall && (q.cnt == BYTE_BITS) && !start_c && !stop_c;
	endsequence

	chk_io_fixed_ack: assert property (addr_end_s and (q.shift[7:1] == IO_MAP_ADDR[7:1]) // [R2]
		|=> (q.st == ST_ACK_ADDR) && q.oe && (q.map == MAP_IO))
		else $error("io map address not acknowledged");
	chk_tx_fixed_ack: assert property (addr_end_s and (q.shift[7:1] == TX_MAP_ADDR[7:1]) // [R3]
		|=> (q.st == ST_ACK_ADDR) && q.oe && (q.map == MAP_TX))
		else $error("tx map address not acknowledged");
	chk_miss_no_ack: assert property (addr_end_s and !hit // [R20]
		|=> (q.st == ST_IDLE) && !q.oe)
		else $error("unmatched address acknowledged");
	chk_stop_to_idle: assert property (stop_c |=> (q.st == ST_IDLE) && !q.oe) // [R1]
		else $error("stop did not return to idle");
	chk_wr_one_cycle: assert property ($rose(q.wr) |=> !q.wr) // [R1]
		else $error("write strobe longer than one cycle");
	chk_read_release: assert property ((q.st == ST_RDATA) ##1 (q.st == ST_ACK_R) |-> !q.oe) // [R1]
		else $error("sda held during host ack");

	// ****************************************
	// Transfer step checks
	// ****************************************

	// End of an offset byte
	sequence offs_end_s;
		(q.st == ST_OFFS) && scl_fall && (q.cnt == BYTE_BITS) && !start_c && !stop_c;
	endsequence

	// End of a write data byte
	sequence wdata_end_s;
		(q.st == ST_WDATA) && scl_fall && (q.cnt == BYTE_BITS) && !start_c && !stop_c;
	endsequence

	// Address acknowledge ends and a read begins
	sequence rd_load_s;
		(q.st == ST_ACK_ADDR) && q.nack && scl_fall && !start_c && !stop_c;
	endsequence

	// Last data bit of a read byte has been shifted out
	sequence rd_last_s;
		(q.st == ST_RDATA) && scl_fall && (4'(q.cnt + CNT_ONE) == BYTE_BITS) && !start_c && !stop_c;
	endsequence

	// Middle bit of a read byte: next bit goes onto the line
	sequence rd_mid_s;
		(q.st == ST_RDATA) && scl_fall && (4'(q.cnt + CNT_ONE) != BYTE_BITS) && !start_c && !stop_c;
	endsequence

	// Clock falls that close a write data acknowledge
	sequence ack_w_fall_s;
		(q.st == ST_ACK_W) && scl_fall && !start_c && !stop_c;
	endsequence

	// Clock falls that close an offset acknowledge
	sequence ack_offs_fall_s;
		(q.st == ST_ACK_OFFS) && scl_fall && !start_c && !stop_c;
	endsequence

	// Host refuses a further read byte
	sequence host_nack_s;
		(q.st == ST_ACK_R) && q.nack && scl_fall && !start_c && !stop_c;
	endsequence

	// A start always reopens the address phase with the line released
	chk_start_to_addr: assert property (start_c // [R1]
		|=> (q.st == ST_ADDR) && (q.cnt == CNT_ZERO) && !q.oe)
		else $error("start did not open address phase");

	// Offset byte is taken as pointer and acknowledged
	chk_offs_ack: assert property (offs_end_s // [R1]
		|=> (q.st == ST_ACK_OFFS) && q.oe && (q.ptr == $past(q.shift)))
		else $error("offset byte not taken");

	// Data byte raises one write strobe and is acknowledged
	chk_wdata_ack: assert property (wdata_end_s // [R1]
		|=> (q.st == ST_ACK_W) && q.oe && q.wr && (q.wdata == $past(q.shift)))
		else $error("data byte not written");

	// Offset acknowledge is released on the next clock fall
	chk_offs_release: assert property (ack_offs_fall_s // [R1]
		|=> (q.st == ST_WDATA) && !q.oe)
		else $error("offset ack not released");

	// Pointer steps after each written byte
	chk_ptr_after_w: assert property (ack_w_fall_s // [R1]
		|=> (q.st == ST_WDATA) && !q.oe && (q.ptr == 8'($past(q.ptr) + PTR_STEP)))
		else $error("pointer not stepped after write");

	// First read bit is on the line right after the address acknowledge
	chk_read_load: assert property (rd_load_s // [R1]
		|=> (q.st == ST_RDATA) && q.rd && (q.oe == ~q.shift[7]))
		else $error("read byte not loaded");

	// Each clock fall before the eighth puts the next read bit on the line
	chk_read_shift: assert property (rd_mid_s // [R1]
		|=> (q.st == ST_RDATA) && (q.oe != q.shift[7]) && (q.shift[7] == $past(q.shift[6])))
		else $error("read bit order broken");

	// After the eighth bit the line is freed and the pointer steps
	chk_read_last: assert property (rd_last_s // [R1]
		|=> (q.st == ST_ACK_R) && !q.oe && (q.ptr == 8'($past(q.ptr) + PTR_STEP)))
		else $error("read byte not closed");

	// Host refusal ends the read
	chk_nack_to_idle: assert property (host_nack_s // [R1]
		|=> (q.st == ST_IDLE) && !q.oe)
		else $error("read went on after host refusal");

	// An idle slave never pulls the data line
	chk_idle_quiet: assert property ((q.st == ST_IDLE) |-> !q.oe) // [R20]
		else $error("idle slave drives data line");

	// Read strobe lasts one cycle
	chk_rd_one_cycle: assert property ($rose(q.rd) |=> !q.rd) // [R1]
		else $error("read strobe longer than one cycle");

	// Selected map only changes at the end of an address byte
	chk_map_hold: assert property (!$stable(q.map) |-> ($past(q.st) == ST_ADDR)) // [R1]
		else $error("map select changed outside address phase");

	for (genvar g = 0; g < PROG_CNT; g++)
	begin : g_chk
		// Programmed nonzero address is answered
		chk_prog_hit: assert property (addr_end_s and (q.addr[g] != PROG_RST) // [R21]
			and (q.shift[7:1] == q.addr[g][7:1]) |=> (q.st == ST_ACK_ADDR) && q.oe)
			else $error("programmed map address not acknowledged");
		// Map address register only moves on a write to its offset
		chk_addr_hold: assert property (!$stable(q.addr[g]) // [R21]
			|-> q.wr && (q.map == MAP_IO) && (q.ptr == PROG_OFFS[g]))
			else $error("map address register changed without a write");
		chk_addr_store: assert property (q.wr && (q.map == MAP_IO) && (q.ptr == PROG_OFFS[g]) // [R21]
			|-> (q.addr[g] == q.wdata))
			else $error("map address register not updated");
		chk_prog_ack: assert property (addr_end_s and (q.addr[g] == PROG_RST) and (q.shift[7:1] == 7'h00) // [R4]
			|=> !q.oe)
			else $error("zero default map reachable");
	end
endmodule : rmad_decode
`default_nettype wire

// File: verif/rmad_host.sv
`timescale 1ns/1ps
`default_nettype none
// Bus host model: drives clock and data, released data reads high
module rmad_host (
	input  wire logic clk_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_out
);
	// Idle bus with both lines released
	initial
	begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	// Whole cycles, so every change lands on a falling edge
	task automatic wt(input int n);
		repeat (n) @(negedge clk_in);
	endtask : wt
	// Data set while the clock is low, sampled late in the clock high
	task automatic bit_x(input logic b, output logic r);
		sda_out = b;
		wt(2);
		scl_out = 1'b1;
		wt(4);
		r = sda_in;
		scl_out = 1'b0;
		wt(2);
	endtask : bit_x
	// Start or repeated start: data falls while the clock is high
	task automatic start;
		sda_out = 1'b1;
		wt(2);
		scl_out = 1'b1;
		wt(4);
		sda_out = 1'b0;
		wt(4);
		scl_out = 1'b0;
		wt(2);
	endtask : start
	// Stop: data rises while the clock is high
	task automatic stop;
		sda_out = 1'b0;
		wt(2);
		scl_out = 1'b1;
		wt(4);
		sda_out = 1'b1;
		wt(4);
	endtask : stop
	// Byte MSB first, then the ninth bit; ack is high when the device pulled low
	task automatic byte_x(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], q[i]);
		bit_x(mack, r);
		ack = ~r;
	endtask : byte_x
endmodule : rmad_host
`default_nettype wire

// File: verif/register_map_address_decode_test.sv
`timescale 1ns/1ps
`default_nettype none
module register_map_address_decode_test;
	import rmad_pkg::*;
	logic       clk_in = 1'b0;
	logic       rst_b_in = 1'b0;
	logic       scl_w, host_sda, sda_w, sda_out, sda_oe_out, map_wr_out, map_rd_out, ak;
	logic [4:0] map_sel_out, wr_sel;
	logic [7:0] map_offs_out, map_wdata_out, map_rdata_in, wr_offs, wr_dat, q0, q1, base, d;
	logic [7:0] wr_seen = 8'h00;
	logic [7:0] rd_seen = 8'h00;
	int         err_total = 0;
	int         checks_done = 0;
	// Open-drain wire with pull-up; map data follows the pointer
	assign sda_w = (sda_oe_out ? sda_out : 1'b1) & host_sda;
	assign map_rdata_in = map_offs_out ^ 8'h5A;
	rmad_decode rmad_decode_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .scl_in(scl_w), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe_out(sda_oe_out), .map_sel_out(map_sel_out), .map_offs_out(map_offs_out),
		.map_wdata_out(map_wdata_out), .map_wr_out(map_wr_out), .map_rd_out(map_rd_out), .map_rdata_in(map_rdata_in));
	rmad_host rmad_host_i (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl_w), .sda_out(host_sda));
	// 25 MHz clock
	initial
		forever #20 clk_in = ~clk_in;
	// Captures each write pulse
	always @(posedge clk_in)
		if (map_wr_out === 1'b1)
		begin
			wr_seen <= wr_seen + 8'h01;
			wr_sel <= map_sel_out;
			wr_offs <= map_offs_out;
			wr_dat <= map_wdata_out;
		end
	// Counts read strobes
	always @(posedge clk_in)
		if (map_rd_out === 1'b1)
			rd_seen <= rd_seen + 8'h01;
	// Bus address given to programmable map i
	function automatic logic [7:0] f_addr(input int i);
		return base + 8'(2 * i);
	endfunction : f_addr
	task automatic close_out;
		if (err_total == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Write one byte at offset o; ok says whether the address is acked
	task automatic do_wr(input logic [7:0] a, input logic [7:0] o, input logic [7:0] v, input logic ok);
		logic [7:0] n0;
		n0 = wr_seen;
		rmad_host_i.start();
		rmad_host_i.byte_x(a, 1'b1, q0, ak);
		chk({7'h00, ak}, {7'h00, ok});
		if (ok)
		begin
			rmad_host_i.byte_x(o, 1'b1, q0, ak);
			rmad_host_i.byte_x(v, 1'b1, q0, ak);
			chk({7'h00, ak}, 8'h01);
			chk(wr_seen - n0, 8'h01);
			chk(wr_offs, o);
			chk(wr_dat, v);
		end
		rmad_host_i.stop();
	endtask : do_wr
	// Set pointer, repeated start, read two bytes into q0 and q1
	task automatic do_rd(input logic [7:0] a, input logic [7:0] o);
		logic [7:0] n0;
		n0 = rd_seen;
		rmad_host_i.start();
		rmad_host_i.byte_x(a, 1'b1, q0, ak);
		rmad_host_i.byte_x(o, 1'b1, q0, ak);
		rmad_host_i.start();
		rmad_host_i.byte_x(a | 8'h01, 1'b1, q0, ak);
		chk({7'h00, ak}, 8'h01);
		rmad_host_i.byte_x(8'hFF, 1'b0, q0, ak);
		rmad_host_i.byte_x(8'hFF, 1'b1, q1, ak);
		rmad_host_i.stop();
		chk(rd_seen - n0, 8'h02);
	endtask : do_rd
	// Main sequence
	initial
	begin
		void'($urandom(32'h10ed));
		base = 8'h42 + 8'(2 * ($urandom % 16));
		repeat (5) @(negedge clk_in);
		rst_b_in = 1'b1;
		rmad_host_i.wt(2);
		chk({7'h00, sda_oe_out}, 8'h00);
		do_wr(IO_MAP_ADDR, 8'h10, 8'($urandom), 1'b1);
		chk({3'h0, wr_sel}, {3'h0, MAP_IO});
		do_wr(TX_MAP_ADDR, 8'h20, 8'($urandom), 1'b1);
		chk({3'h0, wr_sel}, {3'h0, MAP_TX});
		do_wr(f_addr(0), 8'h00, 8'h00, 1'b0);
		do_wr(8'h00, 8'h00, 8'h00, 1'b0);
		for (int i = 0; i < PROG_CNT; i++)
		begin
			do_wr(IO_MAP_ADDR, PROG_OFFS[i], f_addr(i), 1'b1);
			do_wr(f_addr(i), 8'($urandom), 8'($urandom), 1'b1);
			chk({3'h0, wr_sel}, {3'h0, MAP_PROG0 + 5'(i)});
			do_rd(IO_MAP_ADDR, PROG_OFFS[i]);
			chk(q0, f_addr(i));
		end
		d = 8'($urandom);
		do_rd(TX_MAP_ADDR, d);
		chk(q0, d ^ 8'h5A);
		chk(q1, (d + 8'h01) ^ 8'h5A);
		do_wr(IO_MAP_ADDR, PROG_OFFS[3], 8'h9A, 1'b1);
		do_wr(f_addr(3), 8'h00, 8'h00, 1'b0);
		do_wr(8'h9A, 8'h01, 8'h02, 1'b1);
		rst_b_in = 1'b0;
		rmad_host_i.wt(5);
		rst_b_in = 1'b1;
		rmad_host_i.wt(2);
		do_wr(f_addr(0), 8'h00, 8'h00, 1'b0);
		do_rd(IO_MAP_ADDR, PROG_OFFS[0]);
		chk(q0, PROG_RST);
		close_out();
	end
	// Cuts a hung run short
	initial
	begin
		repeat (100000) @(posedge clk_in);
		err_total++;
		$display("[ERR] %0t run did not finish in time", $time);
		close_out();
	end
endmodule : register_map_address_decode_test
`default_nettype wire
